// file: bench/pmc_checker.sv
// port assertions of the mode controller
// assumes a bind onto pmc_top with one clock domain
`timescale 1ns/1ps
`include "pmc_regs.svh"

module pmc_checker #(
	parameter int SENS_W = 8,
	parameter int RST_CYC = 40
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic rtc_alarm,
	input wire logic rtc_en,
	input wire logic rtc_alarm_en,
	input wire logic digital_core_regulator_en,
	input wire logic digital_core_regulator_low,
	input wire logic [SENS_W-1:0] sensor_en,
	input wire logic osc_en,
	input wire logic cpu_run,
	input wire logic supervisor_en,
	input wire logic sys_reset,
	input wire logic boot_rom
);
	// ----
	// helpers
	// ----
	logic [7:0] hi_cnt_q;

	// length of the reset pulse; 8 bits cover the default count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hi_cnt_q <= 8'h00;
		end else if (sys_reset) begin
			hi_cnt_q <= hi_cnt_q + 8'h01;
		end else begin
			hi_cnt_q <= 8'h00;
		end
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// accepted mode request, then the sleep exit steps
	sequence s_req;
		psel && penable && pready && pwrite && !pslverr && paddr == `PMC_OFS_MODE_CTRL;
	endsequence
	sequence s_slp_alarm;
		rtc_alarm && rtc_en && rtc_alarm_en && !digital_core_regulator_en && !sys_reset;
	endsequence
	sequence s_exit;
		sys_reset ##1 sys_reset;
	endsequence

	// ----
	// assertions
	// ----
	AST_PREADY: assert property (psel && penable && !pready |=> pready)
		else $error("pready late");
	AST_RUN: assert property (cpu_run |-> digital_core_regulator_en &&
		!digital_core_regulator_low && osc_en && supervisor_en)
		else $error("run power wrong");
	AST_STBY: assert property (digital_core_regulator_low |-> !cpu_run &&
		!osc_en && sensor_en == '0 && !supervisor_en)
		else $error("standby power wrong");
	AST_SLEEP: assert property (!digital_core_regulator_en && !sys_reset |->
		!osc_en && !cpu_run && sensor_en == '0)
		else $error("sleep power wrong");
	AST_SENS: assert property (sensor_en != '0 |-> cpu_run)
		else $error("sensor on outside run");
	AST_ENTRY: assert property (s_req |-> ##[1:3] !cpu_run)
		else $error("mode entry missed");
	AST_HOLD: assert property ((cpu_run && !psel) [*3] |=> cpu_run)
		else $error("run left without request");
	AST_SYSRST: assert property ($fell(sys_reset) |-> $past(boot_rom) && int'(hi_cnt_q) == RST_CYC)
		else $error("reset pulse wrong");
	AST_WAKE: assert property (s_slp_alarm |-> ##[1:3] s_exit)
		else $error("sleep wake missed");
endmodule

// file: bench/pmc_wake_src.sv
// model of the wake pins and alarm source
// assumes go and sel driven after pclk edges
`timescale 1ns/1ps

module pmc_wake_src (
	input wire logic pclk,
	input wire logic go,
	input wire logic [2:0] sel,
	output logic [3:0] wakeup_pin_group,
	output logic rtc_alarm
);
	logic [1:0] hold_q = 2'h0;
	logic [2:0] sel_q = 3'h0;

	// an event stands three cycles, then returns idle
	always_ff @(posedge pclk) begin
		if (go) begin
			hold_q <= 2'h3;
			sel_q <= sel;
		end else if (hold_q != 2'h0) begin
			hold_q <= hold_q - 2'h1;
		end
	end

	// idle: pins 0,1 pulled up, 2,3 down, so idle never wakes
	always_comb begin
		wakeup_pin_group = 4'h3;
		rtc_alarm = 1'b0;
		if (hold_q != 2'h0 && sel_q < 3'h4) begin
			wakeup_pin_group[sel_q[1:0]] = ~wakeup_pin_group[sel_q[1:0]];
		end
		if (hold_q != 2'h0 && sel_q == 3'h4) begin
			rtc_alarm = 1'b1;
		end
	end
endmodule

// file: bench/test_power_mode_controller.sv
// self-checking bench of the mode controller
// assumes pmc_top, pmc_checker and pmc_wake_src compiled first
`timescale 1ns/1ps
`include "pmc_regs.svh"

module test_power_mode_controller;
	localparam int RST = 4;
	logic pclk, presetn, psel, penable, pwrite, go, pready, pslverr, rtc_alarm;
	logic osc_en, cpu_run, cpu_clk_ext, supervisor_en, rtc_en, rtc_alarm_en;
	logic wake_ctrl_en, sys_reset, boot_rom;
	logic digital_core_regulator_en, digital_core_regulator_low;
	logic [7:0] paddr, sensor_en;
	logic [31:0] pwdata, prdata;
	logic [3:0] wakeup_pin_group;
	logic [2:0] sel;
	logic [4:0] pw;
	int failures = 0;
	int cmp_count = 0;

	// power outputs as one word: run 17, standby 18, sleep 00
	assign pw = {digital_core_regulator_en, digital_core_regulator_low, osc_en, cpu_run,
		supervisor_en};

	pmc_top #(.RST_CYC(RST)) dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .wakeup_pin_group, .rtc_alarm,
		.digital_core_regulator_en, .digital_core_regulator_low, .sensor_en, .osc_en,
		.cpu_run, .cpu_clk_ext, .supervisor_en, .rtc_en, .rtc_alarm_en, .wake_ctrl_en,
		.sys_reset, .boot_rom);
	pmc_wake_src wake_u (.pclk, .go, .sel, .wakeup_pin_group, .rtc_alarm);

	// ----
	// bus and compare tasks
	// ----
	task chk(input logic [31:0] g, input logic [31:0] x);
		cmp_count++;
		if (g !== x) begin
			failures++;
			$display("[FAIL] %0t got %h want %h", $time, g, x);
		end
	endtask

	// one idle cycle after each transfer keeps psel from being set twice
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		// a transfer that never completes is a mismatch of its own
		if (pready !== 1'b1) begin
			failures++;
			$display("[FAIL] %0t no pready on the bus", $time);
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d, input logic xe);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
		chk({31'h0, e}, {31'h0, xe});
	endtask

	task rd(input logic [7:0] a, input logic [31:0] x);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		chk(r, x);
	endtask

	task fire(input logic [2:0] s);
		sel <= s;
		go <= 1'b1;
		@(posedge pclk);
		go <= 1'b0;
	endtask

	task enter(input logic [31:0] c, input logic [4:0] x);
		wr(`PMC_OFS_MODE_CTRL, c, 1'b0);
		@(posedge pclk);
		chk({27'h0, pw}, {27'h0, x});
		chk({24'h0, sensor_en}, 32'h0);
	endtask

	task wait_run();
		int n;
		n = 0;
		while (cpu_run !== 1'b1 && n < 200) begin
			@(posedge pclk);
			n++;
		end
		chk({27'h0, pw}, 32'h17);
	endtask

	// ----
	// scenarios
	// ----
	task t_reset();
		chk({27'h0, pw}, 32'h17);
		rd(`PMC_OFS_MODE_CTRL, 32'h0);
		rd(`PMC_OFS_WAKE_CFG, 32'h0);
		rd(`PMC_OFS_RETAIN, 32'h0);
		$display("reset test done");
	endtask

	task t_run();
		wr(`PMC_OFS_SENSOR_EN, 32'h0000_00A5, 1'b0);
		wr(`PMC_OFS_CLK_SEL, 32'h1, 1'b0);
		// clock select output lags the register by one edge
		@(posedge pclk);
		chk({24'h0, sensor_en}, 32'hA5);
		chk({31'h0, cpu_clk_ext}, 32'h1);
		wr(8'h18, 32'h1, 1'b1);
		wr(`PMC_OFS_MODE_CTRL, 32'h3, 1'b1);
		wr(`PMC_OFS_WAKE_CFG, 32'h0000_00F7, 1'b0);
		fire(3'h0);
		repeat (8) @(posedge pclk);
		rd(`PMC_OFS_MODE_CTRL, 32'h0);
		$display("run test done");
	endtask

	// every pin and the alarm wake standby; cause bit 4+k
	task t_standby();
		for (int k = 0; k < 5; k++) begin
			wr(`PMC_OFS_STATUS, 32'h0000_01F0, 1'b0);
			enter(32'h1, 5'h18);
			wr(`PMC_OFS_SENSOR_EN, 32'h1, 1'b1);
			fire(k[2:0]);
			wait_run();
			rd(`PMC_OFS_STATUS, 32'h10 << k);
		end
		$display("standby test done");
	endtask

	task t_gated();
		wr(`PMC_OFS_WAKE_CFG, 32'h0000_00F3, 1'b0);
		enter(32'h1, 5'h18);
		chk({29'h0, wake_ctrl_en, rtc_alarm_en, rtc_en}, 32'h3);
		fire(3'h0);
		repeat (8) @(posedge pclk);
		chk({27'h0, pw}, 32'h18);
		fire(3'h4);
		wait_run();
		$display("gated test done");
	endtask

	task t_sleep();
		int n;
		logic b;
		wr(`PMC_OFS_RETAIN, 32'hC0DE_1234, 1'b0);
		wr(`PMC_OFS_SENSOR_EN, 32'h0000_00FF, 1'b0);
		enter(32'h2, 5'h00);
		fire(3'h4);
		n = 0;
		while (sys_reset !== 1'b1 && n < 50) begin
			@(posedge pclk);
			n++;
		end
		n = 0;
		b = 1'b0;
		// boot pulse stands in the last cycle of the system reset
		while (sys_reset === 1'b1 && n < 50) begin
			b = boot_rom;
			@(posedge pclk);
			n++;
		end
		chk(32'(n), RST);
		chk({31'h0, b}, 32'h1);
		wait_run();
		rd(`PMC_OFS_RETAIN, 32'hC0DE_1234);
		rd(`PMC_OFS_SENSOR_EN, 32'h0);
		$display("sleep test done");
	endtask

	task print_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// ----
	// clock, sequence and watchdog
	// ----
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	initial begin
		{presetn, psel, penable, pwrite, go} = 5'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		sel = 3'h0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_run();
		t_standby();
		t_gated();
		t_sleep();
		print_verdict();
	end

	// whole run needs about 210 cycles
	initial begin
		#(25 * 20000);
		failures++;
		print_verdict();
	end
endmodule

bind pmc_top pmc_checker #(.SENS_W(SENS_W), .RST_CYC(RST_CYC)) chk_u (.pclk, .presetn, .psel,
	.penable, .pwrite, .paddr, .pready, .pslverr, .rtc_alarm, .rtc_en, .rtc_alarm_en,
	.digital_core_regulator_en, .digital_core_regulator_low, .sensor_en, .osc_en,
	.cpu_run, .supervisor_en, .sys_reset, .boot_rom);

// file: verilog/pmc_pkg.sv
// types shared by the mode controller files
// assumes nothing beyond a SystemVerilog compiler
package pmc_pkg;

	// operating mode, plus the reset step that follows a sleep exit
	typedef enum logic [1:0] {
		PMC_RUN,
		PMC_STANDBY,
		PMC_SLEEP,
		PMC_SLEEP_EXIT
	} pmc_mode_type;

endpackage

// file: verilog/pmc_regs.svh
// register offsets, field positions, reset values and timing counts
// assumes inclusion by bare name from design files of the mode controller
`ifndef PMC_REGS_SVH
`define PMC_REGS_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define PMC_OFS_MODE_CTRL 8'h00
`define PMC_OFS_SENSOR_EN 8'h04
`define PMC_OFS_WAKE_CFG 8'h08
`define PMC_OFS_CLK_SEL 8'h0C
`define PMC_OFS_STATUS 8'h10
`define PMC_OFS_RETAIN 8'h14

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define PMC_MODE_REQ_LSB 0
`define PMC_WCFG_RTC_BIT 0
`define PMC_WCFG_ALARM_BIT 1
`define PMC_WCFG_WCTRL_BIT 2
`define PMC_WCFG_PIN_LSB 4
`define PMC_STAT_MODE_LSB 0
`define PMC_STAT_CAUSE_LSB 4
`define PMC_STAT_ALARM_BIT 8

// ------------------------------------------------------------
// mode request codes and reset values
// ------------------------------------------------------------
`define PMC_REQ_STANDBY 2'h1
`define PMC_REQ_SLEEP 2'h2
`define PMC_SENSOR_EN_RST 8'h00
`define PMC_WAKE_CFG_RST 8'h00
`define PMC_RETAIN_RST 32'h0000_0000

// ------------------------------------------------------------
// timing: system reset pulse after a sleep exit
// ------------------------------------------------------------
`define PMC_CLK_MHZ 40
`define PMC_SYS_RST_NS 1000
`define PMC_SYS_RST_CYC ((`PMC_SYS_RST_NS * `PMC_CLK_MHZ + 999) / 1000)

`endif

// file: verilog/pmc_retain_reg.sv
// general purpose retention register of the mode controller
// assumes it is reset by power-on only, never by the sleep-exit reset
`timescale 1ns/1ps
`include "pmc_regs.svh"

module pmc_retain_reg #(
	parameter int WIDTH = 32
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic wr_en,
	input wire logic [WIDTH-1:0] wr_data,
	output logic [WIDTH-1:0] rd_data_q
);

	// ------------------------------------------------------------
	// storage
	// ------------------------------------------------------------
	// only power-on clears it so software state survives a sleep exit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_data_q <= WIDTH'(`PMC_RETAIN_RST);
		end else if (wr_en) begin
			rd_data_q <= wr_data;
		end
	end

endmodule

// file: verilog/pmc_top.sv
// operating mode controller: run, standby and sleep with wakeup logic
// assumes an apb master on pclk, wake pins and alarm synchronous to pclk
//
// Summary of operation
// [R1] only run, standby and sleep exist; each powers just what it needs
// [R2] run mode enables the digital core regulator fully
// [R3] run mode clocks the processor from internal or external source as selected
// [R4] standby or sleep entry is accepted only from run on software request
// [R5] standby pauses processor execution keeping program state
// [R6] standby lowers core regulator voltage, registers and sram kept
// [R7] standby powers down sensor parts, analog regulators, references automatically
// [R8] standby disables internal oscillator automatically
// [R9] rtc, alarm, wakeup controller stay active in low power only if enabled
// [R10] enabled rtc alarm or enabled wake pin returns to run
// [R11] sleep powers down digital and analog regulators, oscillator, sensor parts
// [R12] sleep exit resets system and starts at first rom instruction
// [R13] retention register survives sleep and the following reset
// [R14] in run, software enables each sensor part individually
// [R15] pins 0 and 1 wake on falling edge, pins 2 and 3 on rising
// [R16] supply supervisor off in sleep and standby, on in run
// [R17] low power entry via mode register write, power down after acceptance
// [R18] wake sources ignored in run, act only in standby or sleep
`timescale 1ns/1ps
`include "pmc_regs.svh"

module pmc_top #(
	parameter int SENS_W = 8,
	parameter int NPIN = 4,
	parameter int RST_CYC = `PMC_SYS_RST_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [NPIN-1:0] wakeup_pin_group,
	input wire logic rtc_alarm,
	output logic digital_core_regulator_en,
	output logic digital_core_regulator_low,
	output logic [SENS_W-1:0] sensor_en,
	output logic osc_en,
	output logic cpu_run,
	output logic cpu_clk_ext,
	output logic supervisor_en,
	output logic rtc_en,
	output logic rtc_alarm_en,
	output logic wake_ctrl_en,
	output logic sys_reset,
	output logic boot_rom
);

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	pmc_pkg::pmc_mode_type mode_q;
	pmc_pkg::pmc_mode_type mode_d;
	logic [SENS_W-1:0] sensor_cfg_q;
	logic [7:0] wake_cfg_q;
	logic clk_sel_q;
	logic [NPIN-1:0] pin_prev_q;
	logic [NPIN-1:0] pin_hit;
	logic [NPIN-1:0] cause_q;
	logic alarm_cause_q;
	logic alarm_hit;
	logic wake;
	logic [15:0] rst_cnt_q;
	logic sys_clear;
	logic acc;
	logic wr;
	logic rd_phase;
	logic mapped;
	logic refuse;
	logic [1:0] req;
	logic [31:0] rd_mux;
	logic [31:0] retain_q;
	logic [31:0] status_word;

	// true in either low power mode
	function automatic logic is_low(input pmc_pkg::pmc_mode_type m);
		is_low = (m == pmc_pkg::PMC_STANDBY) || (m == pmc_pkg::PMC_SLEEP);
	endfunction

	// address decode shared by read and write paths
	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = (a == `PMC_OFS_MODE_CTRL) || (a == `PMC_OFS_SENSOR_EN) ||
			(a == `PMC_OFS_WAKE_CFG) || (a == `PMC_OFS_CLK_SEL) ||
			(a == `PMC_OFS_STATUS) || (a == `PMC_OFS_RETAIN);
	endfunction

	// ------------------------------------------------------------
	// apb slave: one wait state, write lands at the pready edge
	// ------------------------------------------------------------
	assign acc = psel && penable;
	assign rd_phase = acc && !pready;
	assign wr = acc && pready && pwrite && !pslverr;
	assign mapped = is_mapped(paddr);
	assign req = pwdata[`PMC_MODE_REQ_LSB +: 2];
	// config writes outside run cannot be honoured; bad mode codes too
	assign refuse = pwrite && (mode_q != pmc_pkg::PMC_RUN ||
		(paddr == `PMC_OFS_MODE_CTRL && req != `PMC_REQ_STANDBY &&
		req != `PMC_REQ_SLEEP));

	// pready rises one cycle into the access phase, falls right after
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= rd_phase;
		end
	end

	// error flag and read data captured together with pready
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else if (rd_phase) begin
			pslverr <= !mapped || refuse;
			prdata <= pwrite ? 32'h0000_0000 : rd_mux;
		end else begin
			pslverr <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// read mux
	// ------------------------------------------------------------
	assign status_word = {23'h00_0000, alarm_cause_q, 8'(cause_q) << `PMC_STAT_CAUSE_LSB} |
		{30'h0000_0000, mode_q};

	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (paddr)
			`PMC_OFS_MODE_CTRL: rd_mux = {30'h0000_0000, mode_q};
			`PMC_OFS_SENSOR_EN: rd_mux = 32'(sensor_cfg_q);
			`PMC_OFS_WAKE_CFG: rd_mux = {24'h00_0000, wake_cfg_q};
			`PMC_OFS_CLK_SEL: rd_mux = {31'h0000_0000, clk_sel_q};
			`PMC_OFS_STATUS: rd_mux = status_word;
			`PMC_OFS_RETAIN: rd_mux = retain_q;
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// ------------------------------------------------------------
	// software configuration
	// ------------------------------------------------------------
	// the sleep-exit reset clears sensor and clock config, but not wake config or retention
	assign sys_clear = (mode_q == pmc_pkg::PMC_SLEEP_EXIT);

	// per-component sensor enables, writable only while running
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sensor_cfg_q <= SENS_W'(`PMC_SENSOR_EN_RST);
		end else if (sys_clear) begin
			sensor_cfg_q <= SENS_W'(`PMC_SENSOR_EN_RST);
		end else if (wr && paddr == `PMC_OFS_SENSOR_EN) begin
			sensor_cfg_q <= pwdata[SENS_W-1:0]; // [R14]
		end
	end

	// wake sources must be armed here before the low power request
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake_cfg_q <= `PMC_WAKE_CFG_RST;
		end else if (wr && paddr == `PMC_OFS_WAKE_CFG) begin
			wake_cfg_q <= pwdata[7:0]; // [R9]
		end
	end

	// processor clock source selection
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_sel_q <= 1'b0;
		end else if (sys_clear) begin
			clk_sel_q <= 1'b0;
		end else if (wr && paddr == `PMC_OFS_CLK_SEL) begin
			clk_sel_q <= pwdata[0]; // [R3]
		end
	end

	// retention word, untouched by the sleep-exit reset
	pmc_retain_reg #(
		.WIDTH(32)
	) u_retain (
		.pclk(pclk),
		.presetn(presetn),
		.wr_en(wr && paddr == `PMC_OFS_RETAIN), // [R13]
		.wr_data(pwdata),
		.rd_data_q(retain_q)
	);

	// ------------------------------------------------------------
	// wake detection
	// ------------------------------------------------------------
	// pins are synchronous, so one history flop gives the edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_prev_q <= '0;
		end else begin
			pin_prev_q <= wakeup_pin_group;
		end
	end

	// low two pins fall, the rest rise; each gated by its enable
	always_comb begin
		pin_hit = '0;
		for (int i = 0; i < NPIN; i++) begin
			if (i < 2) begin
				pin_hit[i] = pin_prev_q[i] && !wakeup_pin_group[i]; // [R15]
			end else begin
				pin_hit[i] = !pin_prev_q[i] && wakeup_pin_group[i]; // [R15]
			end
			pin_hit[i] = pin_hit[i] && wake_cfg_q[`PMC_WCFG_PIN_LSB + i] &&
				wake_cfg_q[`PMC_WCFG_WCTRL_BIT] && is_low(mode_q); // [R9] [R18]
		end
	end

	assign alarm_hit = rtc_alarm && wake_cfg_q[`PMC_WCFG_RTC_BIT] &&
		wake_cfg_q[`PMC_WCFG_ALARM_BIT] && is_low(mode_q); // [R9] [R18]
	assign wake = alarm_hit || (|pin_hit); // [R10]

	// sticky wake cause, write one to clear; a new hit wins over the clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cause_q <= '0;
			alarm_cause_q <= 1'b0;
		end else begin
			if (wr && paddr == `PMC_OFS_STATUS) begin
				cause_q <= (cause_q & ~pwdata[`PMC_STAT_CAUSE_LSB +: NPIN]) | pin_hit;
				alarm_cause_q <= (alarm_cause_q && !pwdata[`PMC_STAT_ALARM_BIT]) ||
					alarm_hit;
			end else begin
				cause_q <= cause_q | pin_hit;
				alarm_cause_q <= alarm_cause_q || alarm_hit;
			end
		end
	end

	// ------------------------------------------------------------
	// mode state machine
	// ------------------------------------------------------------
	always_comb begin
		mode_d = mode_q;
		unique case (mode_q)
			pmc_pkg::PMC_RUN: begin
				// accepted only from run, by an accepted register write
				if (wr && paddr == `PMC_OFS_MODE_CTRL) begin // [R4] [R17]
					mode_d = (req == `PMC_REQ_SLEEP) ? pmc_pkg::PMC_SLEEP :
						pmc_pkg::PMC_STANDBY;
				end
			end
			pmc_pkg::PMC_STANDBY: begin
				if (wake) begin
					mode_d = pmc_pkg::PMC_RUN; // [R10] [R5]
				end
			end
			pmc_pkg::PMC_SLEEP: begin
				if (wake) begin
					mode_d = pmc_pkg::PMC_SLEEP_EXIT; // [R12]
				end
			end
			pmc_pkg::PMC_SLEEP_EXIT: begin
				if (rst_cnt_q == 16'(RST_CYC - 1)) begin
					mode_d = pmc_pkg::PMC_RUN;
				end
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_q <= pmc_pkg::PMC_RUN;
		end else begin
			mode_q <= mode_d; // [R1]
		end
	end

	// length of the system reset after a sleep exit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rst_cnt_q <= 16'h0000;
		end else if (mode_q == pmc_pkg::PMC_SLEEP_EXIT) begin
			rst_cnt_q <= rst_cnt_q + 16'h0001;
		end else begin
			rst_cnt_q <= 16'h0000;
		end
	end

	// ------------------------------------------------------------
	// power and clock controls, one cycle behind the mode
	// ------------------------------------------------------------
	// outputs follow mode_q so they change only after the request is taken
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			digital_core_regulator_en <= 1'b1;
			digital_core_regulator_low <= 1'b0;
			osc_en <= 1'b1;
			cpu_run <= 1'b1;
			supervisor_en <= 1'b1;
			sensor_en <= '0;
		end else begin
			digital_core_regulator_en <= mode_q != pmc_pkg::PMC_SLEEP; // [R2] [R11]
			digital_core_regulator_low <= mode_q == pmc_pkg::PMC_STANDBY; // [R6] [R17]
			osc_en <= !is_low(mode_q); // [R8] [R11]
			cpu_run <= mode_q == pmc_pkg::PMC_RUN; // [R5]
			supervisor_en <= !is_low(mode_q); // [R16]
			sensor_en <= (mode_q == pmc_pkg::PMC_RUN) ? sensor_cfg_q : '0; // [R7] [R11] [R14]
		end
	end

	// clock source and always-on domain enables
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cpu_clk_ext <= 1'b0;
			rtc_en <= 1'b0;
			rtc_alarm_en <= 1'b0;
			wake_ctrl_en <= 1'b0;
		end else begin
			cpu_clk_ext <= clk_sel_q; // [R3]
			rtc_en <= wake_cfg_q[`PMC_WCFG_RTC_BIT]; // [R9]
			rtc_alarm_en <= wake_cfg_q[`PMC_WCFG_ALARM_BIT]; // [R9]
			wake_ctrl_en <= wake_cfg_q[`PMC_WCFG_WCTRL_BIT]; // [R9]
		end
	end

	// system reset during exit, with a one-cycle boot-from-rom pulse in its last cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sys_reset <= 1'b0;
			boot_rom <= 1'b0;
		end else begin
			sys_reset <= mode_q == pmc_pkg::PMC_SLEEP_EXIT; // [R12]
			boot_rom <= mode_q == pmc_pkg::PMC_SLEEP_EXIT &&
				mode_d == pmc_pkg::PMC_RUN; // [R12]
		end
	end

endmodule
